/* pkg/fsps_defs.vh */
// constants for the flash self-program section controller
`ifndef FSPS_DEFS_VH
`define FSPS_DEFS_VH
// =====================================================
// register offsets (plain port, word index)
`define FSPS_ADDR_CTRL 4'h0
`define FSPS_ADDR_STAT 4'h1
`define FSPS_ADDR_LOCK 4'h2
`define FSPS_ADDR_RSTV 4'h3
// =====================================================
// ctrl register fields
`define FSPS_CTRL_CLR_BUSY 0
`define FSPS_CTRL_CHIP_ERASE 1
// =====================================================
// status register fields
`define FSPS_STAT_BUSY 0
`define FSPS_STAT_STALL 1
`define FSPS_STAT_ACTIVE 2
`define FSPS_STAT_REJECT 3
// =====================================================
// lock register fields and reset value
`define FSPS_LOCK_APP_LO 0
`define FSPS_LOCK_APP_HI 1
`define FSPS_LOCK_BOOT_LO 2
`define FSPS_LOCK_BOOT_HI 3
`define FSPS_LOCK_RESET 4'hF
// =====================================================
// lock mode codes (high bit, low bit)
`define FSPS_LOCK_FREE 2'h3
`define FSPS_LOCK_NO_STORE 2'h2
`define FSPS_LOCK_ALL 2'h0
`define FSPS_LOCK_NO_LOAD 2'h1
// =====================================================
// timing
`define FSPS_PROG_TIME_NS 4000000
`define FSPS_CLK_NS 50
`define FSPS_PROG_CYCLES (`FSPS_PROG_TIME_NS / `FSPS_CLK_NS)
`endif

/* hdl/fsps_region_decode.v */
// region classification of a flash word address
`timescale 1ns/1ps
module fsps_region_decode #(
   parameter AW = 17,
   parameter [16:0] HALT_BASE = 17'h1F000,
   parameter [16:0] BOOT_BASE_0 = 17'h1FE00,
   parameter [16:0] BOOT_BASE_1 = 17'h1FC00,
   parameter [16:0] BOOT_BASE_2 = 17'h1F800,
   parameter [16:0] BOOT_BASE_3 = 17'h1F000
)
(
   input wire [AW-1:0] addr,
   input wire [1:0] boot_size_fuses,
   output wire in_boot,
   output wire in_halt,
   output wire [AW-1:0] boot_base
);
   reg [AW-1:0] base;
   // =====================================================
   // boot split from fuses
   always @*
   begin
      case (boot_size_fuses)
         2'h0: base = BOOT_BASE_3[AW-1:0];
         2'h1: base = BOOT_BASE_2[AW-1:0];
         2'h2: base = BOOT_BASE_1[AW-1:0];
         default: base = BOOT_BASE_0[AW-1:0];
      endcase
   end
   assign boot_base = base;
   assign in_boot = (addr >= base);
   // fixed boundary, every boot base lies at or above it
   assign in_halt = (addr >= HALT_BASE[AW-1:0]) | in_boot;
endmodule

/* hdl/fsps_prog_timer.v */
// page erase or write duration counter
`timescale 1ns/1ps
module fsps_prog_timer #(
   parameter CYCLES = 80000,
   parameter CW = 17
)
(
   input wire clock,
   input wire rst_b,
   input wire start,
   output reg busy_q,
   output reg done_q
);
   reg [CW-1:0] cnt_q;
   // =====================================================
   // countdown
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_q <= {CW{1'b0}};
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (start && !busy_q)
         begin
            cnt_q <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            busy_q <= 1'b1;
         end
         else if (busy_q)
         begin
            if (cnt_q == {CW{1'b0}})
            begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
            else
               cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* hdl/fsps_top.v */
// flash self-program section controller top
//
// Contract
// - store ops fetched from the application region are ignored.
// - store ops from the boot region may target any page, boot included.
// - concurrent-region programming keeps the core running, halting region readable.
// - halting-region programming stalls the core for the whole operation.
// - concurrent region unreadable during any programming operation.
// - busy flag reads one while the concurrent region is blocked.
// - stall decision follows the target address region, not the fetch region.
// - boot region always lies wholly inside the halting region.
// - boot split set by the boot size fuses.
// - fixed concurrent/halting boundary independent of the boot size fuses.
// - application region protected by lock pair zero.
// - boot region protected by lock pair one.
// - application pair: 11 free, 10 no store, 00 both, 01 no load.
// - boot pair decoded symmetrically with the application pair.
// - lock bits set back to one only on a full chip erase; the code also loads all ones on reset.
// - reset vector zero unless boot reset fuse programmed, then boot start.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "fsps_defs.vh"
module fsps_top #(
   parameter AW = 17,
   parameter PROG_CYCLES = `FSPS_PROG_CYCLES,
   parameter CW = 17
)
(
   input wire clock,
   input wire rst_b,
   input wire [AW-1:0] fetch_addr,
   input wire store_req,
   input wire [AW-1:0] store_addr,
   input wire load_req,
   input wire [AW-1:0] load_addr,
   input wire vec_in_boot,
   input wire [1:0] boot_size_fuses,
   input wire boot_reset_fuse,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_q,
   output reg stall_q,
   output reg fetch_block_q,
   output reg load_deny_q,
   output reg store_accept_q,
   output reg irq_block_q,
   output reg flash_prog_q,
   output reg [AW-1:0] reset_vector_q
);
   wire fetch_boot;
   wire fetch_halt;
   wire store_boot;
   wire store_halt;
   wire load_boot;
   wire load_halt;
   wire [AW-1:0] boot_base;
   wire tmr_busy;
   wire tmr_done;
   reg [3:0] lock_q;
   reg busy_q;
   reg halt_op_q;
   reg reject_q;
   reg [3:0] lock_d;
   reg busy_d;
   reg reject_d;
   reg store_ok;
   reg load_ok;
   reg irq_blk;
   reg [7:0] rdata_d;
   wire [1:0] app_mode;
   wire [1:0] boot_mode;
   wire start;

   // =====================================================
   // lock decode helpers
   function store_blocked;
      input [1:0] mode;
      begin
         store_blocked = (mode == `FSPS_LOCK_NO_STORE) || (mode == `FSPS_LOCK_ALL);
      end
   endfunction

   function load_blocked;
      input [1:0] mode;
      begin
         load_blocked = (mode == `FSPS_LOCK_NO_LOAD) || (mode == `FSPS_LOCK_ALL);
      end
   endfunction

   // =====================================================
   // region decoders
   fsps_region_decode #(.AW(AW)) u_fetch_dec (
      .addr(fetch_addr),
      .boot_size_fuses(boot_size_fuses),
      .in_boot(fetch_boot),
      .in_halt(fetch_halt),
      .boot_base(boot_base)
   );

   fsps_region_decode #(.AW(AW)) u_store_dec (
      .addr(store_addr),
      .boot_size_fuses(boot_size_fuses),
      .in_boot(store_boot),
      .in_halt(store_halt),
      .boot_base()
   );

   fsps_region_decode #(.AW(AW)) u_load_dec (
      .addr(load_addr),
      .boot_size_fuses(boot_size_fuses),
      .in_boot(load_boot),
      .in_halt(load_halt),
      .boot_base()
   );

   // =====================================================
   // page operation timer
   fsps_prog_timer #(.CYCLES(PROG_CYCLES), .CW(CW)) u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .start(start),
      .busy_q(tmr_busy),
      .done_q(tmr_done)
   );

   assign app_mode = {lock_q[`FSPS_LOCK_APP_HI], lock_q[`FSPS_LOCK_APP_LO]};
   assign boot_mode = {lock_q[`FSPS_LOCK_BOOT_HI], lock_q[`FSPS_LOCK_BOOT_LO]};

   // =====================================================
   // access permission
   always @*
   begin
      store_ok = 1'b0;
      load_ok = 1'b1;
      irq_blk = 1'b0;
      if (store_req && fetch_boot && !tmr_busy)
      begin
         if (store_boot)
            store_ok = !store_blocked(boot_mode);
         else
            store_ok = !store_blocked(app_mode);
      end
      if (fetch_boot && !load_boot && load_blocked(app_mode))
         load_ok = 1'b0;
      if (!fetch_boot && load_boot && load_blocked(boot_mode))
         load_ok = 1'b0;
      if (tmr_busy && !load_halt)
         load_ok = 1'b0;
      if (busy_q && !load_halt)
         load_ok = 1'b0;
      if (!fetch_boot && vec_in_boot && load_blocked(app_mode))
         irq_blk = 1'b1;
      if (fetch_boot && !vec_in_boot && load_blocked(boot_mode))
         irq_blk = 1'b1;
   end

   assign start = store_ok;

   // =====================================================
   // busy flag, lock and reject state
   always @*
   begin
      busy_d = busy_q;
      lock_d = lock_q;
      reject_d = reject_q;
      if (reg_wr && reg_addr == `FSPS_ADDR_CTRL && reg_wdata[`FSPS_CTRL_CLR_BUSY] && !tmr_busy)
         busy_d = 1'b0;
      if (reg_wr && reg_addr == `FSPS_ADDR_LOCK)
         lock_d = lock_q & reg_wdata[3:0];
      if (reg_wr && reg_addr == `FSPS_ADDR_CTRL && reg_wdata[`FSPS_CTRL_CHIP_ERASE])
         lock_d = `FSPS_LOCK_RESET;
      if (reg_rd && reg_addr == `FSPS_ADDR_STAT)
         reject_d = 1'b0;
      if (store_req && !store_ok)
         reject_d = 1'b1;
      // set wins over clear
      if (start)
         busy_d = 1'b1;
   end

   // =====================================================
   // register read mux
   always @*
   begin
      rdata_d = 8'h00;
      case (reg_addr)
         `FSPS_ADDR_STAT: rdata_d = {4'h0, reject_q, tmr_busy, halt_op_q & tmr_busy, busy_q};
         `FSPS_ADDR_LOCK: rdata_d = {4'h0, lock_q};
         `FSPS_ADDR_RSTV: rdata_d = {7'h00, boot_reset_fuse};
         default: rdata_d = 8'h00;
      endcase
   end

   // =====================================================
   // state registers
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lock_q <= `FSPS_LOCK_RESET;
         busy_q <= 1'b0;
         halt_op_q <= 1'b0;
         reject_q <= 1'b0;
         reg_rdata_q <= 8'h00;
         stall_q <= 1'b0;
         fetch_block_q <= 1'b0;
         load_deny_q <= 1'b0;
         store_accept_q <= 1'b0;
         irq_block_q <= 1'b0;
         flash_prog_q <= 1'b0;
         reset_vector_q <= {AW{1'b0}};
      end
      else
      begin
         lock_q <= lock_d;
         busy_q <= busy_d;
         reject_q <= reject_d;
         reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
         if (start)
            halt_op_q <= store_halt;
         // halting target stalls, concurrent target keeps core running
         stall_q <= start ? store_halt : (tmr_busy && halt_op_q && !tmr_done);
         fetch_block_q <= (start || (tmr_busy && !tmr_done)) ? !fetch_halt : busy_d && !fetch_halt;
         load_deny_q <= load_req && !load_ok;
         store_accept_q <= start;
         irq_block_q <= irq_blk;
         flash_prog_q <= start || (tmr_busy && !tmr_done);
         reset_vector_q <= boot_reset_fuse ? {AW{1'b0}} : boot_base;
      end
   end
endmodule

/* tb/fsps_top_properties.sv */
// assertion checker for the section controller
`timescale 1ns/1ps
`include "fsps_defs.vh"
module fsps_top_chk #(
   parameter AW = 17,
   parameter PROG_CYCLES = 20
)
(
   input wire clock,
   input wire rst_b,
   input wire [AW-1:0] fetch_addr,
   input wire store_req,
   input wire [AW-1:0] store_addr,
   input wire boot_reset_fuse,
   input wire [3:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata_q,
   input wire stall_q,
   input wire fetch_block_q,
   input wire load_deny_q,
   input wire store_accept_q,
   input wire flash_prog_q,
   input wire [AW-1:0] reset_vector_q
);
localparam [16:0] HB = 17'h1F000;
default clocking cb @(posedge clock);
endclocking
default disable iff (!rst_b);
// =====================================================
// properties
property p_app; store_req && fetch_addr < HB |=> !store_accept_q; endproperty
a_app: assert property (p_app) else $error("store from application accepted");
property p_hlt; store_req && store_addr >= HB ##1 store_accept_q |-> stall_q; endproperty
a_hlt: assert property (p_hlt) else $error("halting target without stall");
property p_rww; store_req && store_addr < HB ##1 store_accept_q |-> !stall_q; endproperty
a_rww: assert property (p_rww) else $error("concurrent target stalled");
property p_stp; stall_q |-> flash_prog_q; endproperty
a_stp: assert property (p_stp) else $error("stall without operation");
property p_len; $rose(stall_q) |-> stall_q [*8]; endproperty
a_len: assert property (p_len) else $error("stall too short");
property p_bsy; flash_prog_q && reg_rd && reg_addr == `FSPS_ADDR_STAT |=> reg_rdata_q[0]; endproperty
a_bsy: assert property (p_bsy) else $error("busy flag low during operation");
property p_blk; flash_prog_q && fetch_addr < HB |=> fetch_block_q; endproperty
a_blk: assert property (p_blk) else $error("concurrent fetch not blocked");
property p_rv; boot_reset_fuse |=> reset_vector_q == 0; endproperty
a_rv: assert property (p_rv) else $error("reset vector not zero");
c_hlt: cover property (store_accept_q && stall_q);
c_rww: cover property (store_accept_q && !stall_q);
c_ld: cover property (load_deny_q);
endmodule
bind fsps_top fsps_top_chk #(.AW(AW), .PROG_CYCLES(PROG_CYCLES)) u_chk (.clock(clock), .rst_b(rst_b),
   .fetch_addr(fetch_addr), .store_req(store_req), .store_addr(store_addr), .boot_reset_fuse(boot_reset_fuse),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .stall_q(stall_q),
   .fetch_block_q(fetch_block_q), .load_deny_q(load_deny_q), .store_accept_q(store_accept_q),
   .flash_prog_q(flash_prog_q), .reset_vector_q(reset_vector_q));

/* tb/fsps_core_model.sv */
// core fetch model: steps the program counter unless halted
`timescale 1ns/1ps
module fsps_core_model
(
   input wire clock,
   input wire rst_b,
   input wire halt,
   input wire jump,
   input wire [16:0] target,
   output reg [16:0] pc_q
);
always @(posedge clock or negedge rst_b)
begin
   if (!rst_b)
      pc_q <= 17'h00000;
   else if (jump)
      pc_q <= target;
   else if (!halt)
      pc_q <= pc_q + 17'h00001;
end
endmodule

/* tb/fsps_top_tb.sv */
// self-checking bench for the section controller
`timescale 1ns/1ps
`include "fsps_defs.vh"
module fsps_top_tb;
localparam [16:0] BT = 17'h1FE10;
localparam [16:0] AP = 17'h00100;
reg clock, rst_b, jump, store_req, load_req, vec_in_boot, boot_reset_fuse, reg_wr, reg_rd;
reg [16:0] tgt, store_addr, load_addr, p0;
reg [1:0] boot_size_fuses;
reg [3:0] reg_addr;
reg [7:0] reg_wdata, rdv;
integer miscompares, n_checks, r, m, i;
wire [7:0] reg_rdata_q;
wire [16:0] fetch_addr, reset_vector_q;
wire stall_q, fetch_block_q, load_deny_q, store_accept_q, irq_block_q, flash_prog_q;
fsps_core_model core (.clock(clock), .rst_b(rst_b), .halt(stall_q), .jump(jump), .target(tgt), .pc_q(fetch_addr));
fsps_top #(.PROG_CYCLES(20)) dut (.clock(clock), .rst_b(rst_b), .fetch_addr(fetch_addr), .store_req(store_req),
   .store_addr(store_addr), .load_req(load_req), .load_addr(load_addr), .vec_in_boot(vec_in_boot),
   .boot_size_fuses(boot_size_fuses), .boot_reset_fuse(boot_reset_fuse), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .stall_q(stall_q),
   .fetch_block_q(fetch_block_q), .load_deny_q(load_deny_q), .store_accept_q(store_accept_q),
   .irq_block_q(irq_block_q), .flash_prog_q(flash_prog_q), .reset_vector_q(reset_vector_q));
// =====================================================
// tasks
task chk(input [16:0] got, input [16:0] exp);
begin
   n_checks = n_checks + 1;
   if (got !== exp)
   begin
      miscompares = miscompares + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
   end
end
endtask
task wr(input [3:0] a, input [7:0] d);
begin
   @(posedge clock);
   reg_wr <= 1'b1;
   reg_addr <= a;
   reg_wdata <= d;
   @(posedge clock);
   reg_wr <= 1'b0;
end
endtask
task rd(input [3:0] a);
begin
   @(posedge clock);
   reg_rd <= 1'b1;
   reg_addr <= a;
   @(posedge clock);
   reg_rd <= 1'b0;
   #1 rdv = reg_rdata_q;
end
endtask
task go(input [16:0] a);
begin
   @(posedge clock);
   jump <= 1'b1;
   tgt <= a;
   @(posedge clock);
   jump <= 1'b0;
end
endtask
task req(input s, input [16:0] a);
begin
   @(posedge clock);
   store_req <= s;
   load_req <= !s;
   store_addr <= a;
   load_addr <= a;
   @(posedge clock);
   store_req <= 1'b0;
   load_req <= 1'b0;
   #1;
end
endtask
task fin;
begin
   for (i = 0; i < 100 && flash_prog_q !== 1'b0; i = i + 1)
   begin
      @(posedge clock);
      #1;
   end
   chk(flash_prog_q, 1'b0);
   wr(`FSPS_ADDR_CTRL, 8'h01);
end
endtask
task end_sim;
begin
   $display("checks %0d miscompares %0d", n_checks, miscompares);
   if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
   else
      $display("Checks failed");
   $finish;
end
endtask
// =====================================================
// clock, watchdog and tests
initial
begin
   clock = 1'b0;
   forever #25 clock = ~clock;
end
initial
begin
   #400000;
   miscompares = miscompares + 1;
   end_sim;
end
initial
begin
   {rst_b, jump, store_req, load_req, vec_in_boot, reg_wr, reg_rd} = 7'h00;
   {tgt, store_addr, load_addr, reg_addr, reg_wdata} = 63'h0;
   boot_reset_fuse = 1'b1;
   boot_size_fuses = 2'h3;
   miscompares = 0;
   n_checks = 0;
   repeat (16) @(posedge clock);
   rst_b <= 1'b1;
   rd(`FSPS_ADDR_LOCK);
   chk(rdv[3:0], `FSPS_LOCK_RESET);
   chk(reset_vector_q, 17'h0);
   go(AP);
   req(1'b1, 17'h00200);
   chk(store_accept_q, 1'b0);
   rd(`FSPS_ADDR_STAT);
   chk(rdv[3], 1'b1);
   go(BT);
   req(1'b1, 17'h00200);
   chk({store_accept_q, stall_q}, 2'h2);
   go(17'h00300);
   @(posedge clock);
   #1 chk(fetch_block_q, 1'b1);
   go(17'h1F100);
   @(posedge clock);
   #1 chk({fetch_block_q, stall_q}, 2'h0);
   req(1'b0, 17'h00300);
   chk(load_deny_q, 1'b1);
   req(1'b0, 17'h1F180);
   chk(load_deny_q, 1'b0);
   wr(`FSPS_ADDR_CTRL, 8'h01);
   rd(`FSPS_ADDR_STAT);
   chk(rdv[0], 1'b1);
   fin;
   rd(`FSPS_ADDR_STAT);
   chk(rdv[0], 1'b0);
   go(BT);
   req(1'b1, 17'h1F100);
   chk(stall_q, 1'b1);
   p0 = fetch_addr;
   repeat (17) @(posedge clock);
   #1 chk({stall_q, fetch_addr}, {1'b1, p0});
   repeat (6) @(posedge clock);
   #1 chk({stall_q, flash_prog_q}, 2'h0);
   fin;
   for (r = 0; r < 2; r = r + 1)
      for (m = 0; m < 4; m = m + 1)
      begin
         wr(`FSPS_ADDR_CTRL, 8'h02);
         wr(`FSPS_ADDR_LOCK, r ? {4'hF, m[1:0], 2'h3} : {6'h3F, m[1:0]});
         rd(`FSPS_ADDR_LOCK);
         chk(rdv[3:0], r ? {m[1:0], 2'h3} : {2'h3, m[1:0]});
         vec_in_boot <= (r == 0);
         go(r ? BT : AP);
         @(posedge clock);
         #1 chk(irq_block_q, !m[1]);
         go(r ? AP : BT);
         req(1'b0, r ? 17'h1FE40 : 17'h00200);
         chk(load_deny_q, !m[1]);
         go(BT);
         req(1'b1, r ? 17'h1FE40 : 17'h00200);
         chk(store_accept_q, m[0]);
         fin;
      end
   @(posedge clock);
   rst_b <= 1'b0;
   boot_reset_fuse <= 1'b0;
   boot_size_fuses <= 2'h0;
   repeat (2) @(posedge clock);
   rst_b <= 1'b1;
   @(posedge clock);
   #1 chk(reset_vector_q, 17'h1F000);
   rd(`FSPS_ADDR_RSTV);
   chk(rdv[0], 1'b0);
   for (m = 1; m < 4; m = m + 1)
   begin
      boot_size_fuses <= m[1:0];
      @(posedge clock);
      #1 chk(reset_vector_q, (m == 1) ? 17'h1F800 : (m == 2) ? 17'h1FC00 : 17'h1FE00);
   end
   end_sim;
end
endmodule
